// [design/rtc_cal_defines.vh]
// Register map, field layout, reset values and timing constants
// Assumes: included by the calendar design files, APB with 32-bit data
`ifndef RTC_CAL_DEFINES_VH
`define RTC_CAL_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_DATE_VALUE   8'h00
`define OFS_DATE_MATCH   8'h04
`define OFS_DATE_LOAD    8'h08
`define OFS_YEAR_VALUE   8'h0C
`define OFS_YEAR_MATCH   8'h10
`define OFS_YEAR_LOAD    8'h14
`define OFS_CONTROL      8'h18
`define OFS_IRQ_ENABLE   8'h1C
`define OFS_IRQ_STATUS   8'h20
`define OFS_IRQ_MASKED   8'h24
`define OFS_IRQ_CLEAR    8'h28

// ----------------------------------------------------------------
// Field positions of the date, year, control and interrupt registers
// ----------------------------------------------------------------
`define SEC_HI    5
`define SEC_LO    0
`define MIN_HI    11
`define MIN_LO    6
`define HOUR_HI   16
`define HOUR_LO   12
`define WDAY_HI   19
`define WDAY_LO   17
`define MDAY_HI   24
`define MDAY_LO   20
`define MON_HI    28
`define MON_LO    25
`define DATE_HI   28
`define YEAR_HI   13
`define CTL_EN_BIT 26
`define CTL_LD_BIT 0
`define IRQ_ALARM_BIT 0

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define DATE_VALUE_RST 29'h02120000
`define DATE_MATCH_RST 29'h00000000
`define DATE_LOAD_RST  29'h00000000
`define YEAR_VALUE_RST 14'h2000
`define YEAR_MATCH_RST 14'h2000
`define YEAR_LOAD_RST  14'h0000
`define SEC_MAX   6'h3B
`define HOUR_MAX  5'h17
`define WDAY_MAX  3'h7
`define WDAY_MIN  3'h1
`define MON_MAX   4'hC
`define MON_FEB   4'h2
`define ZERO3     3'h0
`define ZERO4     4'h0
`define ZERO5     5'h0

// ----------------------------------------------------------------
// Timing: one second at 20 MHz
// ----------------------------------------------------------------
`define CLK_HZ        25'd20000000
`define TICK_PERIOD_S 25'd1
`define TICK_CYCLES   (`CLK_HZ * `TICK_PERIOD_S)
`define TICK_W        25

`endif

// [design/rtc_bcd_year.v]
// BCD year counter, four digits, with load and increment
// Assumes: load and increment are one-cycle pulses on clk_i
`timescale 1ns/1ps
`include "rtc_cal_defines.vh"

module rtc_bcd_year
(
    input  wire        clk_i,
    input  wire        rstn_i,
    input  wire        load_i,
    input  wire [13:0] load_val_i,
    input  wire        inc_i,
    output wire [13:0] year_o
);

    reg  [15:0] year_q;
    reg  [15:0] year_d;
    reg         carry;
    integer     k;

    // Decimal increment, digit by digit
    always @*
    begin
        year_d = year_q;
        carry  = 1'b1;
        for (k = 0; k < 4; k = k + 1)
        begin
            if (carry)
            begin
                if (year_q[k*4 +: 4] == 4'h9)
                    year_d[k*4 +: 4] = 4'h0;
                else
                begin
                    year_d[k*4 +: 4] = year_q[k*4 +: 4] + 4'h1;
                    carry = 1'b0;
                end
            end
        end
    end

    // Year register, load wins over increment
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            year_q <= {2'b00, `YEAR_VALUE_RST};
        else if (load_i)
            year_q <= {2'b00, load_val_i};
        else if (inc_i)
            year_q <= {2'b00, year_d[13:0]};
    end

    assign year_o = year_q[13:0];

endmodule

// [design/rtc_tick_gen.v]
// One-second tick generator from the system clock
// Assumes: clk_i at the rate named in the defines header
`timescale 1ns/1ps
`include "rtc_cal_defines.vh"

module rtc_tick_gen
#(
    parameter [24:0] TICK_CYCLES = `TICK_CYCLES
)
(
    input  wire clk_i,
    input  wire rstn_i,
    input  wire run_i,
    output wire tick_o
);

    reg [`TICK_W-1:0] cnt_q;

    // Free count while running, restart when stopped
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            cnt_q <= {`TICK_W{1'b0}};
        else if (!run_i || tick_o)
            cnt_q <= {`TICK_W{1'b0}};
        else
            cnt_q <= cnt_q + 25'h0000001;
    end

    assign tick_o = run_i && (cnt_q == TICK_CYCLES - 25'h0000001);

endmodule

// [design/rtc_calendar.v]
// Calendar registers of the RTC: date and year value, match, load, alarm
// Assumes: APB master on clk_i, 32-bit data, zero-wait slave
`timescale 1ns/1ps
`include "rtc_cal_defines.vh"

// Behaviour
// R01 - Weekday match zero leaves weekday out of comparison; reset value zero
// R02 - Weekday match codes 1 to 7 must equal current weekday
// R03 - Day-of-month match bits 24:20, zero means ignore, else compared
// R04 - Month match bits 28:25, zero means ignore, codes 1 to 12 compared
// R05 - Month match codes 13 to 15 never give an alarm
// R06 - Software loads only 0 to 59 for seconds and minutes
// R07 - Software loads only 0 to 23 for hours
// R08 - Software never loads weekday zero; 1 to 7 are Sunday to Saturday
// R09 - Software loads day of month within the month's length
// R10 - Software loads month only with codes 1 to 12
// R11 - Current year read-only BCD in bits 13:0, reset 0x2000
// R12 - Writable 14-bit BCD year match, reset 0x2000, used for alarm
// R13 - Writable 14-bit BCD year load, reset zero, loaded into counter
// R14 - Second/minute match 60 to 63, hour match 24 to 31 never match
// R15 - Enable bit starts calendar; later control writes ignored until reset
// R16 - Raw status bit shows alarm interrupt before masking
// R17 - Alarm when all compared fields equal current values
module rtc_calendar
#(
    parameter [24:0] TICK_CYCLES = `TICK_CYCLES
)
(
    input  wire        clk_i,
    input  wire        rstn_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    output wire        irq_o,
    output wire        enabled_o
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Days in a month; BCD year gives leap years (every fourth year)
    function [4:0] month_len;
        input [3:0]  mon;
        input [13:0] yr;
        reg   [7:0]  lo;
        begin
            lo = yr[7:0];
            case (mon)
                4'h2:    month_len = (((lo[7:4] * 4'hA + lo[3:0]) & 8'h03) == 8'h00) ? 5'h1D : 5'h1C;
                4'h4,
                4'h6,
                4'h9,
                4'hB:    month_len = 5'h1E;
                default: month_len = 5'h1F;
            endcase
        end
    endfunction

    // Field compare that is skipped when the match field is zero
    function opt_eq;
        input [5:0] want;
        input [5:0] have;
        begin
            opt_eq = (want == 6'h00) || (want == have);
        end
    endfunction

    // Completed write to one register offset
    function wr_hit;
        input       wr;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            wr_hit = wr && (addr == ofs);
        end
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [28:0] date_q;
    reg  [28:0] date_match_q;
    reg  [28:0] date_load_q;
    reg  [13:0] year_match_q;
    reg  [13:0] year_load_q;
    reg         enable_q;
    reg         alarm_raw_q;
    reg         alarm_en_q;
    reg         match_prev_q;
    reg  [28:0] date_d;

    wire        wr_en;
    wire        tick;
    wire [13:0] year_now;
    wire        load_year;
    wire        year_wrap;
    wire        match_now;
    wire        alarm_set;
    wire        alarm_clr;

    assign wr_en     = psel_i && penable_i && pwrite_i;
    assign pready_o  = 1'b1;
    assign pslverr_o = 1'b0;
    assign enabled_o = enable_q;

    // Field views of the running date
    wire [5:0] cur_sec  = date_q[`SEC_HI:`SEC_LO];
    wire [5:0] cur_min  = date_q[`MIN_HI:`MIN_LO];
    wire [4:0] cur_hour = date_q[`HOUR_HI:`HOUR_LO];
    wire [2:0] cur_wday = date_q[`WDAY_HI:`WDAY_LO];
    wire [4:0] cur_mday = date_q[`MDAY_HI:`MDAY_LO];
    wire [3:0] cur_mon  = date_q[`MON_HI:`MON_LO];

    // Field views of the match register
    wire [5:0] m_sec  = date_match_q[`SEC_HI:`SEC_LO];
    wire [5:0] m_min  = date_match_q[`MIN_HI:`MIN_LO];
    wire [4:0] m_hour = date_match_q[`HOUR_HI:`HOUR_LO];
    wire [2:0] weekday_alarm_field  = date_match_q[`WDAY_HI:`WDAY_LO];
    wire [4:0] monthday_alarm_field = date_match_q[`MDAY_HI:`MDAY_LO];
    wire [3:0] month_alarm_field    = date_match_q[`MON_HI:`MON_LO];

    // ----------------------------------------------------------------
    // Sub-blocks
    // ----------------------------------------------------------------
    rtc_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick
    (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .run_i  (enable_q),                                         // [R15]
        .tick_o (tick)
    );

    // Year rolls when 31 December 23:59:59 ticks over
    assign year_wrap = tick && (cur_sec == `SEC_MAX) && (cur_min == `SEC_MAX) && (cur_hour == `HOUR_MAX)
                       && (cur_mon == `MON_MAX) && (cur_mday == month_len(cur_mon, year_now));
    assign load_year = wr_hit(wr_en, paddr_i, `OFS_YEAR_LOAD);

    rtc_bcd_year u_year
    (
        .clk_i      (clk_i),
        .rstn_i     (rstn_i),
        .load_i     (load_year),                                    // [R13]
        .load_val_i (pwdata_i[`YEAR_HI:0]),
        .inc_i      (year_wrap),
        .year_o     (year_now)                                      // [R11]
    );

    // ----------------------------------------------------------------
    // Calendar counter
    // ----------------------------------------------------------------

    // Next date one second later; load values are trusted as legal
    always @*
    begin
        date_d = date_q;
        if (cur_sec != `SEC_MAX)
            date_d[`SEC_HI:`SEC_LO] = cur_sec + 6'h01;
        else
        begin
            date_d[`SEC_HI:`SEC_LO] = 6'h00;
            if (cur_min != `SEC_MAX)
                date_d[`MIN_HI:`MIN_LO] = cur_min + 6'h01;
            else
            begin
                date_d[`MIN_HI:`MIN_LO] = 6'h00;
                if (cur_hour != `HOUR_MAX)
                    date_d[`HOUR_HI:`HOUR_LO] = cur_hour + 5'h01;
                else
                begin
                    date_d[`HOUR_HI:`HOUR_LO] = `ZERO5;
                    // Weekday 1..7 is Sunday..Saturday
                    date_d[`WDAY_HI:`WDAY_LO] = (cur_wday == `WDAY_MAX) ? `WDAY_MIN : cur_wday + 3'h1; // [R08]
                    if (cur_mday < month_len(cur_mon, year_now))                                       // [R09]
                        date_d[`MDAY_HI:`MDAY_LO] = cur_mday + 5'h01;
                    else
                    begin
                        date_d[`MDAY_HI:`MDAY_LO] = 5'h01;
                        date_d[`MON_HI:`MON_LO] = (cur_mon == `MON_MAX) ? 4'h1 : cur_mon + 4'h1;   // [R10]
                    end
                end
            end
        end
    end

    // Running date: load from the load register when the year is loaded,
    // so that date and year move together; otherwise count each tick
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            date_q <= `DATE_VALUE_RST;
        else if (load_year)
            date_q <= date_load_q;                                  // [R06] [R07]
        else if (tick)
            date_q <= date_d;
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------

    // Alarm match fields of the date
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            date_match_q <= `DATE_MATCH_RST;                        // [R01]
        else if (wr_hit(wr_en, paddr_i, `OFS_DATE_MATCH))
            date_match_q <= pwdata_i[`DATE_HI:0];
    end

    // Date preset, moved into the counter by a year load
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            date_load_q <= `DATE_LOAD_RST;
        else if (wr_hit(wr_en, paddr_i, `OFS_DATE_LOAD))
            date_load_q <= pwdata_i[`DATE_HI:0];
    end

    // Year alarm value
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            year_match_q <= `YEAR_MATCH_RST;                        // [R12]
        else if (wr_hit(wr_en, paddr_i, `OFS_YEAR_MATCH))
            year_match_q <= pwdata_i[`YEAR_HI:0];
    end

    // Year preset, kept for readback after the load
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            year_load_q <= `YEAR_LOAD_RST;                          // [R13]
        else if (wr_hit(wr_en, paddr_i, `OFS_YEAR_LOAD))
            year_load_q <= pwdata_i[`YEAR_HI:0];
    end

    // Control locks once the enable is set, until the next reset
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            enable_q <= 1'b0;
        else if (wr_hit(wr_en, paddr_i, `OFS_CONTROL) && !enable_q)
            enable_q <= pwdata_i[`CTL_EN_BIT];                      // [R15]
    end

    // Interrupt enable, writable at any time
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            alarm_en_q <= 1'b0;
        else if (wr_hit(wr_en, paddr_i, `OFS_IRQ_ENABLE))
            alarm_en_q <= pwdata_i[`IRQ_ALARM_BIT];
    end

    // ----------------------------------------------------------------
    // Alarm compare
    // ----------------------------------------------------------------

    // Per-field results; out-of-range match codes never match, so a
    // stray code cannot raise a false alarm
    wire sec_ok  = (m_sec == cur_sec) && (m_sec <= `SEC_MAX);                   // [R14]
    wire min_ok  = (m_min == cur_min) && (m_min <= `SEC_MAX);                   // [R14]
    wire hour_ok = (m_hour == cur_hour) && (m_hour <= `HOUR_MAX);               // [R14]

    // Optional fields at zero are left out of the comparison
    wire wday_ok = opt_eq({3'b000, weekday_alarm_field}, {3'b000, cur_wday});   // [R01] [R02]
    wire mday_ok = opt_eq({1'b0, monthday_alarm_field}, {1'b0, cur_mday});      // [R03]
    wire mon_ok  = opt_eq({2'b00, month_alarm_field}, {2'b00, cur_mon})         // [R04]
                   && (month_alarm_field <= `MON_MAX);                          // [R05]
    wire year_ok = (year_match_q == year_now);                                  // [R12]

    // Alarm only when every field agrees
    assign match_now = sec_ok && min_ok && hour_ok && wday_ok && mday_ok && mon_ok && year_ok; // [R17]

    // Raise only on the edge of a new match, so a cleared flag stays clear
    assign alarm_set = match_now && !match_prev_q;
    assign alarm_clr = wr_hit(wr_en, paddr_i, `OFS_IRQ_CLEAR) && pwdata_i[`IRQ_ALARM_BIT];

    // Sticky raw status; set wins over clear
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            alarm_raw_q  <= 1'b0;
            match_prev_q <= 1'b0;
        end
        else
        begin
            match_prev_q <= match_now;
            if (alarm_set)
                alarm_raw_q <= 1'b1;                                // [R16]
            else if (alarm_clr)
                alarm_raw_q <= 1'b0;
        end
    end

    wire calendar_alarm_raw_flag = alarm_raw_q;
    assign irq_o = calendar_alarm_raw_flag && alarm_en_q;

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    reg [31:0] rdata;

    // Unmapped and write-only addresses read as zero
    always @*
    begin
        rdata = 32'h00000000;
        case (paddr_i)
            `OFS_DATE_VALUE: rdata = {3'b000, date_q};
            `OFS_DATE_MATCH: rdata = {3'b000, date_match_q};
            `OFS_DATE_LOAD:  rdata = {3'b000, date_load_q};
            `OFS_YEAR_VALUE: rdata = {18'h00000, year_now};         // [R11]
            `OFS_YEAR_MATCH: rdata = {18'h00000, year_match_q};
            `OFS_YEAR_LOAD:  rdata = {18'h00000, year_load_q};
            `OFS_CONTROL:    rdata = {5'h00, enable_q, 26'h0000000};
            `OFS_IRQ_ENABLE: rdata = {31'h00000000, alarm_en_q};
            `OFS_IRQ_STATUS: rdata = {31'h00000000, calendar_alarm_raw_flag}; // [R16]
            `OFS_IRQ_MASKED: rdata = {31'h00000000, irq_o};
            default:         rdata = 32'h00000000;
        endcase
    end

    // Read data is captured from the mux in the setup cycle, so the
    // access phase presents a flop output that cannot change under it
    reg [31:0] prdata_q;

    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            prdata_q <= 32'h00000000;
        else if (psel_i && !penable_i && !pwrite_i)
            prdata_q <= rdata;
    end

    assign prdata_o = prdata_q;

endmodule

// [tb/rtc_calendar_monitor.sv]
// Concurrent checks on the calendar register block ports
// Assumes: bound to the top module, offsets from the shared defines header
`timescale 1ns/1ps
`include "rtc_cal_defines.vh"

module rtc_calendar_monitor
#(
    parameter [24:0] TICK_CYCLES = `TICK_CYCLES
)
(
    input wire        clk_i,
    input wire        rstn_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pwrite_i,
    input wire [7:0]  paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire        pready_o,
    input wire        pslverr_o,
    input wire        irq_o,
    input wire        enabled_o
);
    // ----------------------------------------------------------------
    // Completed accesses and shadow copies of writable registers
    // ----------------------------------------------------------------
    wire       wr_acc = psel_i & penable_i & pwrite_i;
    wire       rd_acc = psel_i & penable_i & ~pwrite_i;
    wire       en_wr  = wr_acc & (paddr_i == `OFS_CONTROL) & pwdata_i[`CTL_EN_BIT];
    wire       irq_wr = wr_acc & ((paddr_i == `OFS_IRQ_ENABLE) | (paddr_i == `OFS_IRQ_CLEAR));
    reg [28:0] dm_q;
    reg [13:0] ym_q;
    reg [13:0] yl_q;

    // Shadows follow each completed write
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            dm_q <= `DATE_MATCH_RST;
            ym_q <= `YEAR_MATCH_RST;
            yl_q <= `YEAR_LOAD_RST;
        end
        else if (wr_acc)
        begin
            if (paddr_i == `OFS_DATE_MATCH) dm_q <= pwdata_i[28:0];
            if (paddr_i == `OFS_YEAR_MATCH) ym_q <= pwdata_i[13:0];
            if (paddr_i == `OFS_YEAR_LOAD) yl_q <= pwdata_i[13:0];
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_enable_sticks: assert property (!$fell(enabled_o)) else $error("enable dropped");
    a_enable_cause: assert property ($rose(enabled_o) |-> $past(en_wr)) else $error("enable without write");
    a_enable_takes: assert property (en_wr |=> enabled_o) else $error("enable write lost");
    a_year_upper_zero: assert property (rd_acc && paddr_i == `OFS_YEAR_VALUE |-> prdata_o[31:14] == 18'h0)
        else $error("year upper bits set");
    a_year_match_read: assert property (rd_acc && paddr_i == `OFS_YEAR_MATCH |-> prdata_o == {18'h0, ym_q})
        else $error("year match readback");
    a_year_load_read: assert property (rd_acc && paddr_i == `OFS_YEAR_LOAD |-> prdata_o == {18'h0, yl_q})
        else $error("year load readback");
    a_date_match_read: assert property (rd_acc && paddr_i == `OFS_DATE_MATCH |-> prdata_o == {3'h0, dm_q})
        else $error("date match readback");
    a_raw_when_irq: assert property (rd_acc && paddr_i == `OFS_IRQ_STATUS && $past(irq_o) |-> prdata_o[0])
        else $error("irq without raw status");
    a_irq_fall_cause: assert property ($fell(irq_o) |-> $past(irq_wr)) else $error("irq dropped unasked");
    a_alarm_fields_valid: assert property ($rose(irq_o) && !$past(irq_wr) |-> dm_q[28:25] <= 4'hC &&
        dm_q[5:0] <= 6'h3B && dm_q[11:6] <= 6'h3B && dm_q[16:12] <= 5'h17) else $error("alarm on invalid match");
endmodule

bind rtc_calendar rtc_calendar_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_monitor
(
    .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .irq_o(irq_o), .enabled_o(enabled_o)
);

// [tb/rtc_calendar_tb_top.sv]
// Self-checking bench of the calendar register block over APB
// Assumes: design files and defines header, a short tick of eight clocks
`timescale 1ns/1ps
`include "rtc_cal_defines.vh"

module rtc_calendar_tb_top;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    wire  [31:0] prdata_o;
    wire         pready_o, pslverr_o, irq_o, enabled_o;
    integer      num_errors = 0;
    integer      n_tests = 0;
    integer      seed = 32'hDFB0;
    integer      i;
    logic [31:0] rd, ld, v;

    // Clock of 50 ns period
    always #25 clk_i = ~clk_i;

    rtc_calendar #(.TICK_CYCLES(25'h8)) dut
    (
        .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .irq_o(irq_o), .enabled_o(enabled_o)
    );

    // ----------------------------------------------------------------
    // Report, compare and bus tasks
    // ----------------------------------------------------------------
    task tally_and_finish;
    begin
        if (num_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer k;
    begin
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        k = 0;
        @(posedge clk_i);
        while (pready_o !== 1'b1 && k < 16)
        begin
            k = k + 1;
            @(posedge clk_i);
        end
        rd = prdata_o;
        if (k == 16)
        begin
            num_errors = num_errors + 1;
            tally_and_finish;
        end
        else
        begin
            psel_i <= 1'b0;
            penable_i <= 1'b0;
            @(posedge clk_i);
        end
    end
    endtask

    task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    begin
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    end
    endtask

    function logic [31:0] mk(input logic [7:0] s, mi, h, wd, md, mo);
        mk = {3'h0, mo[3:0], md[4:0], wd[2:0], h[4:0], mi[5:0], s[5:0]};
    endfunction

    // Load a date at second zero, arm a match at second three, watch the alarm
    task try_alarm(input logic [31:0] ldw, input logic [31:0] mw, input logic [13:0] ym, input logic ex);
        logic seen;
    begin
        apb(1'b1, `OFS_DATE_MATCH, mw);
        apb(1'b1, `OFS_YEAR_MATCH, {18'h0, ym});
        apb(1'b1, `OFS_DATE_LOAD, ldw);
        apb(1'b1, `OFS_YEAR_LOAD, 32'h2024);
        apb(1'b1, `OFS_IRQ_CLEAR, 32'h1);
        seen = 1'b0;
        repeat (60)
        begin
            @(posedge clk_i);
            seen = seen | (irq_o === 1'b1);
        end
        chk("alarm irq", {31'h0, ex}, {31'h0, seen});
        rdchk("raw status", `OFS_IRQ_STATUS, {31'h0, ex});
    end
    endtask

    // Hang guard well above the length of the whole run
    initial
    begin
        #2000000;
        num_errors = num_errors + 1;
        tally_and_finish;
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        rdchk("date value", `OFS_DATE_VALUE, 32'h02120000);
        rdchk("year value", `OFS_YEAR_VALUE, 32'h00002000);
        rdchk("year match", `OFS_YEAR_MATCH, 32'h00002000);
        rdchk("year load", `OFS_YEAR_LOAD, 32'h0);
        rdchk("date match", `OFS_DATE_MATCH, 32'h0);
        rdchk("date load", `OFS_DATE_LOAD, 32'h0);
        v = $random(seed);
        apb(1'b1, `OFS_YEAR_VALUE, v);
        rdchk("year value ro", `OFS_YEAR_VALUE, 32'h00002000);
        apb(1'b1, `OFS_YEAR_MATCH, v);
        rdchk("year match rw", `OFS_YEAR_MATCH, {18'h0, v[13:0]});
        v = $random(seed) & 32'h00003777;
        apb(1'b1, `OFS_DATE_LOAD, mk(0, 0, 0, 1, 1, 1));
        apb(1'b1, `OFS_YEAR_LOAD, v);
        rdchk("year load rw", `OFS_YEAR_LOAD, {18'h0, v[13:0]});
        rdchk("unmapped", 8'h40, 32'h0);
        chk("enable idle", 32'h0, {31'h0, enabled_o});
        apb(1'b1, `OFS_CONTROL, 32'h04000000);
        apb(1'b1, `OFS_CONTROL, 32'h0);
        chk("enable sticky", 32'h1, {31'h0, enabled_o});
        apb(1'b1, `OFS_IRQ_ENABLE, 32'h1);
        ld = mk(0, 10, 3, 2, 15, 6);
        apb(1'b1, `OFS_DATE_LOAD, ld);
        rdchk("date load rw", `OFS_DATE_LOAD, ld);
        apb(1'b1, `OFS_YEAR_LOAD, 32'h2024);
        apb(1'b0, `OFS_DATE_VALUE, 32'h0);
        chk("loaded date", ld, rd & 32'hFFFFFFC0);
        rdchk("loaded year", `OFS_YEAR_VALUE, 32'h2024);
        try_alarm(ld, mk(3, 10, 3, 0, 0, 0), 14'h2024, 1'b1);
        apb(1'b1, `OFS_IRQ_ENABLE, 32'h0);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        rdchk("masked status", `OFS_IRQ_MASKED, 32'h0);
        rdchk("raw kept", `OFS_IRQ_STATUS, 32'h1);
        apb(1'b1, `OFS_IRQ_ENABLE, 32'h1);
        chk("irq unmasked", 32'h1, {31'h0, irq_o});
        rdchk("masked set", `OFS_IRQ_MASKED, 32'h1);
        for (i = 1; i < 8; i = i + 1)
            try_alarm(ld, mk(3, 10, 3, i, 0, 0), 14'h2024, i == 2);
        try_alarm(ld, mk(3, 10, 3, 0, 15, 0), 14'h2024, 1'b1);
        try_alarm(ld, mk(3, 10, 3, 0, 16, 0), 14'h2024, 1'b0);
        for (i = 0; i < 16; i = i + 1)
            try_alarm(ld, mk(3, 10, 3, 0, 0, i), 14'h2024, i == 0 || i == 6);
        try_alarm(ld, mk(3, 10, 3, 2, 15, 6), 14'h2025, 1'b0);
        try_alarm(ld, mk(60, 10, 3, 0, 0, 0), 14'h2024, 1'b0);
        try_alarm(ld, mk(3, 10, 24, 0, 0, 0), 14'h2024, 1'b0);
        try_alarm(ld, mk(3, 11, 3, 0, 0, 0), 14'h2024, 1'b0);
        for (i = 0; i < 4; i = i + 1)
        begin
            v = mk(0, $unsigned($random(seed)) % 60, $unsigned($random(seed)) % 24, 1 + $unsigned($random(seed)) % 7,
                1 + $unsigned($random(seed)) % 28, 1 + $unsigned($random(seed)) % 12);
            try_alarm(v, v | 32'h3, 14'h2024, 1'b1);
        end
        tally_and_finish;
    end
endmodule
